// ---- rtl/sacp_port.sv ----
// Serial control and result port of a 10-bit successive-approximation converter.
//
// Behaviour
// - Chip select fall resets counters, enables port.
// - Chip select rise disables port, ignores activity.
// - Four-bit command picks input, rate, power-down.
// - After four command bits, input ignored.
// - Result output three-stated while deselected.
// - Selected: output shows first result bit.
// - Frame sync starts command and result frame, only once the result is ready.
// - Done flag low after readout, high when ready.
// - Ten-bit results, ten bits shifted per frame.
// - Codes 0-7 select inputs; four-input mapping.
// - Code 8 powers down; next access clears.
// - Code 9 selects fast rate, no result.
// - Code A selects slow rate, no result.
// - Code B converts mid-scale, result 200h.
// - Code C converts zero-scale, result 000h.
// - Code D converts full-scale, result 3FFh.
// - Command in and result out share clock.
`timescale 1ns/10ps
module sacp_port #(
    parameter int unsigned FAST_CNT = sacp_pkg::FAST_CYCLES,
    parameter int unsigned SLOW_CNT = sacp_pkg::SLOW_CYCLES,
    parameter bit          FOUR_IN  = 1'b0
) (
    input  wire logic       clock,
    input  wire logic       nrst,
    input  wire logic       serial_clock_input,
    input  wire logic       chip_select_n,
    input  wire logic       frame_sync_input,
    input  wire logic       serial_command_input,
    output logic            serial_result_output,
    output logic            serial_result_oe,
    output logic            conversion_done_flag,
    output logic            power_down,
    output logic            conv_start,
    output logic [2:0]      conv_channel,
    input  wire logic [9:0] conv_sample
);

    // ------------------------------------------------------------------
    // Link domain: shift command in and result out on the serial clock
    // ------------------------------------------------------------------
    // Chip select is sampled on the serial clock, which runs freely.
    logic                  csn_s1_r, csn_s2_r;
    logic                  csn_s1_nxt, csn_s2_nxt;
    sacp_pkg::sacp_ser_t   ser_r, ser_nxt;
    logic [3:0]            bit_cnt_r, bit_cnt_nxt;
    logic [3:0]            cmd_sr_r, cmd_sr_nxt;
    logic [9:0]            out_sr_r, out_sr_nxt;
    logic                  out_r, out_nxt;
    logic                  oe_r, oe_nxt;
    logic                  frm_tgl_r, frm_tgl_nxt;
    logic [3:0]            frm_cmd_r, frm_cmd_nxt;
    // Result word crossing from system domain, held stable while flag is high.
    logic [9:0]            res_l1_r, res_l2_r;
    logic                  rdy_l1_r, rdy_l2_r;
    // Reset as seen in the link domain, and system state that the link reads.
    logic                  nrst_l1_r, nrst_l_r;
    logic                  done_r, done_nxt;
    logic [9:0]            conv_res_r, conv_res_nxt;

    always_comb begin
        csn_s1_nxt  = chip_select_n;
        csn_s2_nxt  = csn_s1_r;
        ser_nxt     = ser_r;
        bit_cnt_nxt = bit_cnt_r;
        cmd_sr_nxt  = cmd_sr_r;
        out_sr_nxt  = out_sr_r;
        out_nxt     = out_r;
        oe_nxt      = ~csn_s2_r;
        frm_tgl_nxt = frm_tgl_r;
        frm_cmd_nxt = frm_cmd_r;
        if (csn_s2_r) begin
            ser_nxt     = sacp_pkg::SER_IDLE;
            bit_cnt_nxt = 4'h0;
            out_sr_nxt  = res_l2_r;
            out_nxt     = res_l2_r[sacp_pkg::RES_W-1];
        end else begin
            case (ser_r)
                sacp_pkg::SER_IDLE: begin
                    out_nxt = out_sr_r[sacp_pkg::RES_W-1];
                    // Reload while the result stands, so a late crossing settles first.
                    if (rdy_l2_r) begin
                        out_sr_nxt = res_l2_r;
                        out_nxt    = res_l2_r[sacp_pkg::RES_W-1];
                    end
                    if (frame_sync_input && rdy_l2_r) begin
                        ser_nxt     = sacp_pkg::SER_SHIFT;
                        bit_cnt_nxt = 4'h0;
                    end
                end
                sacp_pkg::SER_SHIFT: begin
                    // Both directions move on the same edge.
                    if (bit_cnt_r < 4'(sacp_pkg::CMD_W)) begin
                        cmd_sr_nxt = {cmd_sr_r[2:0], serial_command_input};
                    end
                    out_sr_nxt  = {out_sr_r[8:0], 1'b0};
                    out_nxt     = out_sr_r[sacp_pkg::RES_W-2];
                    bit_cnt_nxt = bit_cnt_r + 4'h1;
                    if (bit_cnt_r == 4'(sacp_pkg::RES_W - 1)) begin
                        ser_nxt     = sacp_pkg::SER_DONE;
                        frm_cmd_nxt = cmd_sr_r;
                        frm_tgl_nxt = ~frm_tgl_r;
                    end
                end
                sacp_pkg::SER_DONE: begin
                    out_nxt = 1'b0;
                    if (!rdy_l2_r) begin
                        ser_nxt    = sacp_pkg::SER_IDLE;
                        out_sr_nxt = res_l2_r;
                    end
                end
                default: ser_nxt = sacp_pkg::SER_IDLE;
            endcase
        end
    end

    always_ff @(posedge serial_clock_input) begin
        csn_s1_r <= csn_s1_nxt;
        csn_s2_r <= csn_s2_nxt;
        res_l1_r <= conv_res_r;
        res_l2_r <= res_l1_r;
        rdy_l1_r <= done_r;
        rdy_l2_r <= rdy_l1_r;
        if (!nrst_l_r) begin
            ser_r     <= sacp_pkg::SER_IDLE;
            bit_cnt_r <= 4'h0;
            cmd_sr_r  <= 4'h0;
            out_sr_r  <= sacp_pkg::RES_RST;
            out_r     <= 1'b0;
            oe_r      <= 1'b0;
            frm_tgl_r <= 1'b0;
            frm_cmd_r <= 4'h0;
        end else begin
            ser_r     <= ser_nxt;
            bit_cnt_r <= bit_cnt_nxt;
            cmd_sr_r  <= cmd_sr_nxt;
            out_sr_r  <= out_sr_nxt;
            out_r     <= out_nxt;
            oe_r      <= oe_nxt;
            frm_tgl_r <= frm_tgl_nxt;
            frm_cmd_r <= frm_cmd_nxt;
        end
    end

    // Reset brought into the link domain.
    always_ff @(posedge serial_clock_input) begin
        nrst_l1_r <= nrst;
        nrst_l_r  <= nrst_l1_r;
    end

    // ------------------------------------------------------------------
    // System domain: decode command, time conversion, drive outputs
    // ------------------------------------------------------------------
    logic [2:0]  tg_r;
    logic [3:0]  cmd_m1_r;
    logic        pd_r, pd_nxt;
    logic        slow_r, slow_nxt;
    logic        busy_r, busy_nxt;
    logic        start_r, start_nxt;
    logic [2:0]  chan_r, chan_nxt;
    logic [9:0]  pend_r, pend_nxt;
    logic        pend_ext_r, pend_ext_nxt;
    logic [sacp_pkg::CNT_W-1:0] tmr_r, tmr_nxt;
    logic        frame_ev;

    // Toggle crossing: third stage is compared only with the second.
    assign frame_ev = tg_r[2] ^ tg_r[1];

    always_comb begin
        done_nxt     = done_r;
        pd_nxt       = pd_r;
        slow_nxt     = slow_r;
        busy_nxt     = busy_r;
        start_nxt    = 1'b0;
        chan_nxt     = chan_r;
        conv_res_nxt = conv_res_r;
        pend_nxt     = pend_r;
        pend_ext_nxt = pend_ext_r;
        tmr_nxt      = tmr_r;
        if (frame_ev) begin
            done_nxt = 1'b0;
            pd_nxt   = 1'b0;
            busy_nxt = 1'b1;
            tmr_nxt  = slow_r ? sacp_pkg::CNT_W'(SLOW_CNT) : sacp_pkg::CNT_W'(FAST_CNT);
            pend_ext_nxt = 1'b0;
            pend_nxt     = conv_res_r;
            if (cmd_m1_r[3] == 1'b0) begin
                chan_nxt     = FOUR_IN ? {1'b0, cmd_m1_r[2:1]} : cmd_m1_r[2:0];
                pend_ext_nxt = 1'b1;
                start_nxt    = 1'b1;
            end else begin
                case (cmd_m1_r)
                    sacp_pkg::CMD_PDOWN: pd_nxt   = 1'b1;
                    sacp_pkg::CMD_FAST:  slow_nxt = 1'b0;
                    sacp_pkg::CMD_SLOW:  slow_nxt = 1'b1;
                    sacp_pkg::CMD_MID:   pend_nxt = sacp_pkg::RES_MID;
                    sacp_pkg::CMD_ZERO:  pend_nxt = sacp_pkg::RES_ZERO;
                    sacp_pkg::CMD_FULL:  pend_nxt = sacp_pkg::RES_FULL;
                    default:             pend_nxt = conv_res_r;
                endcase
            end
        end else if (busy_r) begin
            if (tmr_r <= sacp_pkg::CNT_W'(1)) begin
                busy_nxt     = 1'b0;
                done_nxt     = 1'b1;
                conv_res_nxt = pend_ext_r ? conv_sample : pend_r;
            end else begin
                tmr_nxt = tmr_r - sacp_pkg::CNT_W'(1);
            end
        end
    end

    always_ff @(posedge clock) begin
        // The command word is taken on the edge that the toggle reaches the second stage,
        // one clock after the first stage saw it, so the word has long settled.
        tg_r     <= {tg_r[1:0], frm_tgl_r};
        cmd_m1_r <= frm_cmd_r;
        if (!nrst) begin
            done_r     <= 1'b1;
            pd_r       <= 1'b0;
            slow_r     <= 1'b0;
            busy_r     <= 1'b0;
            start_r    <= 1'b0;
            chan_r     <= 3'h0;
            conv_res_r <= sacp_pkg::RES_RST;
            pend_r     <= sacp_pkg::RES_RST;
            pend_ext_r <= 1'b0;
            tmr_r      <= '0;
        end else begin
            done_r     <= done_nxt;
            pd_r       <= pd_nxt;
            slow_r     <= slow_nxt;
            busy_r     <= busy_nxt;
            start_r    <= start_nxt;
            chan_r     <= chan_nxt;
            conv_res_r <= conv_res_nxt;
            pend_r     <= pend_nxt;
            pend_ext_r <= pend_ext_nxt;
            tmr_r      <= tmr_nxt;
        end
    end

    always_ff @(posedge serial_clock_input) begin
        serial_result_output <= out_nxt;
        serial_result_oe     <= oe_nxt;
    end

    always_ff @(posedge clock) begin
        conversion_done_flag <= done_r;
        power_down           <= pd_r;
        conv_start           <= start_r;
        conv_channel         <= chan_r;
    end

endmodule : sacp_port

// ---- rtl/sacp_pkg.sv ----
// Package of constants for the converter serial control and result port.
package sacp_pkg;

    // ------------------------------------------------------------------
    // Widths and command codes
    // ------------------------------------------------------------------
    localparam int unsigned CMD_W     = 4;
    localparam int unsigned RES_W     = 10;
    localparam logic [3:0]  CMD_PDOWN = 4'h8;
    localparam logic [3:0]  CMD_FAST  = 4'h9;
    localparam logic [3:0]  CMD_SLOW  = 4'hA;
    localparam logic [3:0]  CMD_MID   = 4'hB;
    localparam logic [3:0]  CMD_ZERO  = 4'hC;
    localparam logic [3:0]  CMD_FULL  = 4'hD;
    localparam logic [9:0]  RES_MID   = 10'h200;
    localparam logic [9:0]  RES_ZERO  = 10'h000;
    localparam logic [9:0]  RES_FULL  = 10'h3FF;
    localparam logic [9:0]  RES_RST   = 10'h000;

    // ------------------------------------------------------------------
    // Conversion timing
    // ------------------------------------------------------------------
    localparam int unsigned CLK_MHZ     = 100;
    localparam int unsigned FAST_MS     = 10;
    localparam int unsigned SLOW_MS     = 40;
    localparam int unsigned FAST_CYCLES = FAST_MS * 1000 * 1000 * CLK_MHZ / 1000;
    localparam int unsigned SLOW_CYCLES = SLOW_MS * 1000 * 1000 * CLK_MHZ / 1000;
    localparam int unsigned CNT_W       = 32;

    // ------------------------------------------------------------------
    // Serial-side state
    // ------------------------------------------------------------------
    typedef enum logic [2:0] {
        SER_IDLE  = 3'b001,
        SER_SHIFT = 3'b010,
        SER_DONE  = 3'b100
    } sacp_ser_t;

endpackage : sacp_pkg

// ---- testbench/sacp_port_asserts.sv ----
// Checker of port timing relations for the converter serial port.
`timescale 1ns/10ps
module sacp_port_asserts #(
    parameter int unsigned FAST_CNT = 50,
    parameter int unsigned SLOW_CNT = 200
) (
    input wire logic clock,
    input wire logic nrst,
    input wire logic chip_select_n,
    input wire logic serial_result_oe,
    input wire logic conversion_done_flag,
    input wire logic power_down,
    input wire logic conv_start
);
    logic [3:0]  hi_r;
    logic [3:0]  lo_r;
    logic [31:0] busy_r;

    // Count select levels and busy cycles so that waits carry exact bounds.
    always_ff @(posedge clock) begin
        if (!nrst) begin
            hi_r   <= 4'h0;
            lo_r   <= 4'h0;
            busy_r <= 32'h0;
        end else begin
            hi_r   <= !chip_select_n ? 4'h0 : (hi_r == 4'hF ? hi_r : hi_r + 4'h1);
            lo_r   <= chip_select_n ? 4'h0 : (lo_r == 4'hF ? lo_r : lo_r + 4'h1);
            busy_r <= conversion_done_flag ? 32'h0 : busy_r + 32'h1;
        end
    end

    default clocking cb @(posedge clock); endclocking
    default disable iff (!nrst);

    sequence s_busy;
        !conversion_done_flag;
    endsequence

    property p_oe_off;   hi_r == 4'hF |-> !serial_result_oe; endproperty
    property p_oe_on;    lo_r == 4'hF |-> serial_result_oe; endproperty
    property p_busy_min; $rose(conversion_done_flag) |-> busy_r + 2 >= FAST_CNT; endproperty
    property p_busy_max; busy_r <= SLOW_CNT + 16; endproperty
    property p_fall_sel; $fell(conversion_done_flag) |-> !chip_select_n; endproperty
    property p_start;    conv_start |-> ##[0:8] s_busy; endproperty
    property p_pulse;    conv_start |=> !conv_start; endproperty
    property p_pd_quiet; power_down |-> !conv_start; endproperty
    property p_pd_sel;   $rose(power_down) |-> !chip_select_n; endproperty

    a_oe_off:   assert property (p_oe_off) else $error("pin driven while deselected");
    a_oe_on:    assert property (p_oe_on) else $error("pin idle while selected");
    a_busy_min: assert property (p_busy_min) else $error("busy too short");
    a_busy_max: assert property (p_busy_max) else $error("busy too long");
    a_fall_sel: assert property (p_fall_sel) else $error("busy while deselected");
    a_start:    assert property (p_start) else $error("start without busy");
    a_pulse:    assert property (p_pulse) else $error("start too long");
    a_pd_quiet: assert property (p_pd_quiet) else $error("start in power down");
    a_pd_sel:   assert property (p_pd_sel) else $error("power down unselected");
endmodule : sacp_port_asserts

bind sacp_port sacp_port_asserts #(.FAST_CNT(FAST_CNT), .SLOW_CNT(SLOW_CNT)) u_sacp_port_asserts (
    .clock(clock), .nrst(nrst), .chip_select_n(chip_select_n),
    .serial_result_oe(serial_result_oe), .conversion_done_flag(conversion_done_flag),
    .power_down(power_down), .conv_start(conv_start));

// ---- testbench/sacp_host_model.sv ----
// Host serial port model that frames commands and collects results.
`timescale 1ns/10ps
module sacp_host_model (
    input  wire logic sclk,
    output logic      cs_n,
    output logic      fs,
    output logic      cmd,
    input  wire logic dout,
    input  wire logic done
);
    initial begin
        cs_n = 1'b1;
        fs   = 1'b0;
        cmd  = 1'b0;
    end

    task automatic frame(input logic [3:0] c, output logic [9:0] r, output bit ok);
        int n;
        @(negedge sclk) fs = 1'b1;
        @(negedge sclk) fs = 1'b0;
        cs_n = 1'b0;
        repeat (4) @(negedge sclk);
        fs = 1'b1;
        @(negedge sclk) fs = 1'b0;
        for (int i = 0; i < 10; i++) begin
            cmd      = (i < 4) ? c[3 - i] : ~cmd;
            r[9 - i] = dout;
            @(negedge sclk);
        end
        n = 0;
        while (done === 1'b1 && n < 64) begin
            @(negedge sclk);
            n++;
        end
        ok = (n < 64);
        while (done !== 1'b1 && n < 2000) begin
            @(negedge sclk);
            n++;
        end
        ok     = ok && (n < 2000);
        cs_n = 1'b1;
    endtask : frame
endmodule : sacp_host_model

// ---- testbench/sacp_port_test.sv ----
// Self-checking bench for the converter serial control and result port.
`timescale 1ns/10ps
module sacp_port_test;
    localparam int unsigned FAST = 50;
    localparam int unsigned SLOW = 200;
    typedef struct packed {
        logic [3:0] cmd;
        logic [9:0] follow;
    } sacp_row_t;
    logic       clock, nrst, sclk, cs_n, fs, cmd, dout, oe, done, pd, start;
    logic [2:0] chan;
    logic [9:0] sample, got, exp;
    bit         ok;
    int         bad_count, checked, lowc, lim;
    sacp_row_t  rows [17];

    sacp_port #(.FAST_CNT(FAST), .SLOW_CNT(SLOW), .FOUR_IN(1'b0)) u_sacp_port (
        .clock(clock), .nrst(nrst), .serial_clock_input(sclk), .chip_select_n(cs_n),
        .frame_sync_input(fs), .serial_command_input(cmd), .serial_result_output(dout),
        .serial_result_oe(oe), .conversion_done_flag(done), .power_down(pd),
        .conv_start(start), .conv_channel(chan), .conv_sample(sample));
    sacp_host_model u_sacp_host_model (.sclk(sclk), .cs_n(cs_n), .fs(fs), .cmd(cmd),
        .dout(dout), .done(done));

    initial begin
        clock = 1'b0;
        forever #5 clock = ~clock;
    end
    initial begin
        sclk = 1'b0;
        #3;
        forever #16 sclk = ~sclk;
    end
    always @(negedge clock) sample <= 10'h155 ^ {7'h00, chan};
    always @(posedge clock) lowc <= done ? lowc : lowc + 1;

    task automatic chk(input string what, input logic [9:0] e, input logic [9:0] g);
        checked++;
        if (g !== e) begin
            bad_count++;
            $display("CHECK FAILED %s expected %h seen %h", what, e, g);
        end
    endtask : chk

    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", checked, bad_count);
        if (bad_count == 0 && checked > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : report_and_stop

    initial begin
        #400000;
        bad_count++;
        $display("CHECK FAILED watchdog expected finish seen timeout");
        report_and_stop();
    end

    initial begin
        rows = '{{4'h0, 10'h155}, {4'h1, 10'h154}, {4'h2, 10'h157}, {4'h3, 10'h156},
                 {4'h4, 10'h151}, {4'h5, 10'h150}, {4'h6, 10'h153}, {4'h7, 10'h152},
                 {4'hB, 10'h200}, {4'h9, 10'h200}, {4'hC, 10'h000}, {4'hA, 10'h000},
                 {4'hD, 10'h3FF}, {4'h8, 10'h3FF}, {4'hE, 10'h3FF}, {4'hF, 10'h3FF},
                 {4'h0, 10'h155}};
        nrst   = 1'b0;
        sample = 10'h000;
        lowc   = 0;
        exp    = sacp_pkg::RES_RST;
        repeat (13) @(negedge clock);
        nrst = 1'b1;
        repeat (24) @(negedge clock);
        for (int i = 0; i < 17; i++) begin
            lowc = 0;
            u_sacp_host_model.frame(rows[i].cmd, got, ok);
            chk("readout", exp, got);
            chk("handshake", 10'h001, {9'h000, ok});
            chk("power down", {9'h000, rows[i].cmd == sacp_pkg::CMD_PDOWN}, {9'h000, pd});
            if (i > 0 && rows[i - 1].cmd inside {sacp_pkg::CMD_FAST, sacp_pkg::CMD_SLOW}) begin
                lim = (rows[i - 1].cmd == sacp_pkg::CMD_SLOW) ? SLOW : FAST;
                chk("busy span", 10'h001, {9'h000, lowc >= lim && lowc < lim + 40});
            end
            exp = rows[i].follow;
        end
        $display("test command table done");
        nrst = 1'b0;
        repeat (13) @(negedge clock);
        chk("reset state", 10'h004, {7'h00, done, oe, pd});
        nrst = 1'b1;
        repeat (24) @(negedge clock);
        u_sacp_host_model.frame(sacp_pkg::CMD_MID, got, ok);
        chk("reset readout", sacp_pkg::RES_RST, got);
        u_sacp_host_model.frame(sacp_pkg::CMD_FULL, got, ok);
        chk("mid scale", sacp_pkg::RES_MID, got);
        $display("test mid-run reset done");
        report_and_stop();
    end
endmodule : sacp_port_test
